// *** rtl/phy_rx_pins.sv ***
// MAC-facing receive, clock and shared interrupt pins of a 10/100 PHY
// Contract
// - Management clock treated as an asynchronous domain
// - Receive data on rising clock, valid qualifies
// - Four data bits in MII, two in RMII
// - Valid pin is RX_DV, or CRS_DV in RMII
// - MII receive clock 25 or 2.5 MHz
// - RMII master drives 50 MHz reference clock out
// - RMII slave leaves receive clock pin undriven
// - Error output high on error symbol, clock-timed
// - Error flagged for every error, idle included
// - Error strap latched at power-up only
// - Shared pin low means power-down by default
// - Interrupt mode pulls shared pin open-drain low
// - MII transmit clock 25 or 2.5 MHz
// - Transmit clock phase fixed to reference clock
// - Transmit clock pin unused in RMII
// - Reference 25 MHz, or 50 MHz in RMII
`timescale 1ns/1ns
`include "phy_rx_pins_consts.svh"
module phy_rx_pins #(
  parameter int DIV = `DIV_10M
) (
  input wire logic sys_clk,        // System clock, 20 MHz
  input wire logic arst_n,         // Pin reset, active low
  input wire logic por_n,          // Power-up reset, active low
  input wire logic link_clk,       // Device reference clock
  input wire logic rmii_mode,      // 1: RMII, 0: MII
  input wire logic rmii_master,    // RMII: 1 master, 0 slave
  input wire logic speed_100,      // 1: 100 Mbps, 0: 10 Mbps
  input wire logic mdc_pin,        // Management clock pin
  output logic mdc_rise,           // Management clock rising, pulse
  input wire logic [3:0] core_rxd, // Decoded receive data
  input wire logic core_rx_dv,     // Decoded data valid
  input wire logic core_crs,       // Carrier present
  input wire logic core_rx_err,    // Error symbol seen
  input wire logic [3:0] rxd_i,    // Receive data pins, in
  output logic [3:0] rxd_o,        // Receive data pins, out
  output logic [3:0] rxd_oe,       // Receive data pins, enable
  input wire logic rx_dv_i,        // Valid pin, in
  output logic rx_dv_o,            // Valid pin, out
  output logic rx_dv_oe,           // Valid pin, enable
  input wire logic rx_er_i,        // Error pin, in
  output logic rx_er_o,            // Error pin, out
  output logic rx_er_oe,           // Error pin, enable
  input wire logic rx_clk_i,       // Receive clock pin, in
  output logic rx_clk_o,           // Receive clock pin, out
  output logic rx_clk_oe,          // Receive clock pin, enable
  output logic tx_clk_o,           // Transmit clock pin, out
  output logic tx_clk_oe,          // Transmit clock pin, enable
  input wire logic int_i,          // Shared pin, in
  output logic int_o,              // Shared pin, out
  output logic int_oe,             // Shared pin, enable
  input wire logic int_mode,       // 1: shared pin is interrupt
  input wire logic int_req,        // Interrupt condition, level
  output logic power_down,         // Power-down request, level
  output logic [5:0] strap_q,      // Latched strap levels
  output logic rx_clk_seen         // Receive clock pin level
);
  phy_rx_pins_pkg::boot_state_t state_q;
  phy_rx_pins_pkg::boot_state_t state_d;
  phy_rx_pins_pkg::pin_mode_t mode;

  // System domain: pin synchronisers
  logic [`STRAP_W-1:0] strap_s1;
  logic [`STRAP_W-1:0] strap_s2;
  logic mdc_s1;
  logic mdc_s2;
  logic mdc_s3;
  logic int_s1;
  logic int_s2;
  logic rck_s1;
  logic rck_s2;

  always_ff @(posedge sys_clk) begin
    strap_s1 <= {rx_er_i, rx_dv_i, rxd_i};
    strap_s2 <= strap_s1;
  end

  // Receive clock pin level, for the slave case where the MAC drives it
  always_ff @(posedge sys_clk) begin
    rck_s1 <= rx_clk_i;
    rck_s2 <= rck_s1;
  end

  // Management clock: own domain, only its rising edge is reported
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
    end else begin
      mdc_s1 <= mdc_pin;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
    end
  end
  // No timeout on the clock, so any slower rate or a stopped clock works
  assign mdc_rise = mdc_s2 & ~mdc_s3;

  // Shared pin: power-down input, or open-drain interrupt
  logic pd_q;
  logic pd_d;
  assign pd_d = ~int_mode & ~int_s2;

  // Synchroniser idles at the pull-up level, so reset shows no low pulse
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_s1 <= 1'h1;
      int_s2 <= 1'h1;
    end else begin
      int_s1 <= int_i;
      int_s2 <= int_s1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_q <= 1'h0;
    end else begin
      pd_q <= pd_d;
    end
  end
  assign power_down = pd_q;
  assign int_o = 1'b0;
  assign int_oe = int_mode & int_req;

  // Boot sequence: hold pins as inputs, sample straps, then drive
  wire sys_rst_n = arst_n & por_n;
  logic [`STRAP_SETTLE_W-1:0] settle_q;
  logic [`STRAP_SETTLE_W-1:0] settle_d;
  wire settled = (settle_q == `STRAP_SETTLE_CYC);
  wire latch_now = (state_q == phy_rx_pins_pkg::st_sample);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      phy_rx_pins_pkg::st_hold: begin
        if (settled) begin
          state_d = phy_rx_pins_pkg::st_sample;
        end
      end
      phy_rx_pins_pkg::st_sample: begin
        state_d = phy_rx_pins_pkg::st_run;
      end
      phy_rx_pins_pkg::st_run: begin
        state_d = phy_rx_pins_pkg::st_run;
      end
      default: begin
        state_d = phy_rx_pins_pkg::st_hold;
      end
    endcase
  end
  assign settle_d = settled ? settle_q :
                    settle_q + `STRAP_SETTLE_W'(1);

  always_ff @(posedge sys_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      state_q <= phy_rx_pins_pkg::st_hold;
      settle_q <= '0;
    end else begin
      state_q <= state_d;
      settle_q <= settle_d;
    end
  end

  // Straps other than the error pin are rescanned on every reset
  logic [`STRAP_ER_BIT-1:0] strap_lo_q;
  logic [`STRAP_ER_BIT-1:0] strap_lo_d;
  assign strap_lo_d = latch_now ? strap_s2[`STRAP_ER_BIT-1:0] :
                      strap_lo_q;

  always_ff @(posedge sys_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      strap_lo_q <= `STRAP_ER_BIT'(`STRAP_RST);
    end else begin
      strap_lo_q <= strap_lo_d;
    end
  end

  // Error strap: cleared and taken only after power-up
  logic er_taken_q;
  logic er_taken_d;
  logic strap_er_q;
  logic strap_er_d;
  wire take_er = latch_now & ~er_taken_q;
  assign er_taken_d = er_taken_q | take_er;
  assign strap_er_d = take_er ? strap_s2[`STRAP_ER_BIT] : strap_er_q;

  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      er_taken_q <= 1'h0;
      strap_er_q <= 1'h0;
    end else begin
      er_taken_q <= er_taken_d;
      strap_er_q <= strap_er_d;
    end
  end
  assign strap_q = {strap_er_q, strap_lo_q};

  wire drive_sys = (state_q == phy_rx_pins_pkg::st_run);
  assign rx_clk_seen = rck_s2;

  // Link domain reset: asserts at once, releases on a link clock edge
  logic lrst_s1;
  logic lrst_s2;
  always_ff @(posedge link_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      lrst_s1 <= 1'h0;
      lrst_s2 <= 1'h0;
    end else begin
      lrst_s1 <= 1'h1;
      lrst_s2 <= lrst_s1;
    end
  end
  wire link_rst_n = lrst_s2;

  // Link domain: configuration and drive enable cross by two flip-flops
  logic [3:0] cfg_s1;
  logic [3:0] cfg_s2;
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cfg_s1 <= 4'h0;
      cfg_s2 <= 4'h0;
    end else begin
      cfg_s1 <= {drive_sys, speed_100, rmii_master, rmii_mode};
      cfg_s2 <= cfg_s1;
    end
  end
  wire l_rmii = cfg_s2[0];
  wire l_master = cfg_s2[1];
  wire l_fast = cfg_s2[2];
  wire l_drive = cfg_s2[3];

  assign mode = !l_rmii ? phy_rx_pins_pkg::mode_mii :
                l_master ? phy_rx_pins_pkg::mode_rmii_master :
                phy_rx_pins_pkg::mode_rmii_slave;

  wire is_mii = (mode == phy_rx_pins_pkg::mode_mii);
  wire is_master = (mode == phy_rx_pins_pkg::mode_rmii_master);

  // Media clock: reference itself at 100 Mbps and in RMII, else divided
  clk_div_if mclk ();
  assign mclk.bypass = l_fast | l_rmii;

  media_clk_div #(
    .DIV(DIV)
  ) u_div (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .div(mclk.gen)
  );

  // Receive outputs take new values on each rising media clock edge
  logic [3:0] rxd_sel;
  logic dv_sel;
  logic [3:0] rxd_d;
  logic dv_d;
  logic er_d;
  logic [3:0] rxd_q;
  logic dv_q;
  logic er_q;

  assign rxd_sel = is_mii ? core_rxd :
                   {2'h0, core_rxd[`RXD_RMII_W-1:0]};
  assign dv_sel = is_mii ? core_rx_dv :
                  (core_crs | core_rx_dv);
  assign rxd_d = mclk.rise ? rxd_sel : rxd_q;
  assign dv_d = mclk.rise ? dv_sel : dv_q;
  assign er_d = mclk.rise ? core_rx_err : er_q;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rxd_q <= `RXD_RST;
      dv_q <= 1'h0;
      er_q <= 1'h0;
    end else begin
      rxd_q <= rxd_d;
      dv_q <= dv_d;
      er_q <= er_d;
    end
  end

  assign rxd_o = rxd_q;
  assign rx_dv_o = dv_q;
  assign rx_er_o = er_q;

  wire upper_used = l_drive & is_mii;
  wire rck_used = l_drive & (is_mii | is_master);
  wire tck_used = l_drive & is_mii;

  // Pins turn to outputs only once the boot sequence has released them
  assign rxd_oe[`RXD_RMII_W-1:0] = {`RXD_RMII_W{l_drive}};
  assign rxd_oe[`RXD_MII_W-1:`RXD_RMII_W] =
    {(`RXD_MII_W - `RXD_RMII_W){upper_used}};
  assign rx_dv_oe = l_drive;
  assign rx_er_oe = l_drive;

  // Receive clock pin: media clock in MII, 50 MHz reference in master
  assign rx_clk_o = is_mii ? mclk.clk_out : link_clk;
  assign rx_clk_oe = rck_used;

  // Transmit clock pin: media clock, the reference itself at 100 Mbps, MII only
  assign tx_clk_o = mclk.clk_out;
  assign tx_clk_oe = tck_used;
endmodule

// *** rtl/phy_rx_pins_consts.svh ***
// Constants for the receive-side pin block
`ifndef PHY_RX_PINS_CONSTS_SVH
`define PHY_RX_PINS_CONSTS_SVH

// Device reference clock in MII mode, in kHz
`define REF_MII_KHZ 25000
// RMII reference clock, in kHz
`define REF_RMII_KHZ 50000
// Media clock at 10 Mbps, in kHz
`define CLK_10M_KHZ 2500
// Reference cycles per 10 Mbps clock period, derived from the rates
`define DIV_10M (`REF_MII_KHZ / `CLK_10M_KHZ)
// Fastest management clock the station may run, in kHz
`define MDC_MAX_KHZ 25000

// Nibble width in MII, dibit width in RMII
`define RXD_MII_W 4
`define RXD_RMII_W 2

// Strap pin vector: rx data [3:0], valid at 4, error at 5
`define STRAP_W 6
`define STRAP_DV_BIT 4
`define STRAP_ER_BIT 5

// System cycles that strap levels settle after reset release
`define STRAP_SETTLE_W 4
`define STRAP_SETTLE_CYC 4'h8

// Reset values
`define RXD_RST 4'h0
`define STRAP_RST 6'h00

`endif

// *** rtl/phy_rx_pins_pkg.sv ***
// Types shared by the receive-side pin block
package phy_rx_pins_pkg;

  typedef enum logic [1:0] {
    mode_mii,
    mode_rmii_master,
    mode_rmii_slave
  } pin_mode_t;

  typedef enum logic [1:0] {
    st_hold,
    st_sample,
    st_run
  } boot_state_t;

endpackage

// *** rtl/clk_div_if.sv ***
// Carrier between the media clock divider and its user
`timescale 1ns/1ns
interface clk_div_if;
  logic bypass;
  logic clk_out;
  logic rise;

  modport gen (
    input bypass,
    output clk_out,
    output rise
  );

  modport sink (
    output bypass,
    input clk_out,
    input rise
  );
endinterface

// *** rtl/media_clk_div.sv ***
// Media clock divider locked to the reference clock
`timescale 1ns/1ns
`include "phy_rx_pins_consts.svh"
module media_clk_div #(
  parameter int DIV = `DIV_10M
) (
  input wire logic clk,       // Reference clock
  input wire logic rst_n,     // Asynchronous reset, active low
  clk_div_if.gen div          // Divider controls and outputs
);
  localparam int HALF = DIV / 2;
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic clk_q;
  logic clk_d;
  wire term = (cnt_q == LAST);

  assign cnt_d = term ? '0 : cnt_q + CW'(1);
  assign clk_d = term ? ~clk_q : clk_q;
  // Counter starts at reset, so the divided edge keeps a fixed phase
  assign div.clk_out = div.bypass ? clk : clk_q;
  assign div.rise = div.bypass | (term & ~clk_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end
endmodule

// *** bench/mac_station_model.sv ***
// Far side: management station clock, pin pulls and shared-pin driver
`timescale 1ns/1ns
module mac_station_model (
  output logic mdc_pin,        // Management clock, idle low
  input wire logic pd_drive_n, // Station pulls shared pin low
  input wire logic int_o,      // Device shared pin out
  input wire logic int_oe,     // Device shared pin enable
  output wire logic int_i,     // Shared pin level
  input wire logic rx_clk_o,   // Device clock pin out
  input wire logic rx_clk_oe,  // Device clock pin enable
  output wire logic rx_clk_i   // Clock pin level
);
  // Pull-up unless someone pulls the pin low
  assign int_i = !((int_oe && !int_o) || !pd_drive_n);
  // Pull-down while the device leaves the pin alone
  assign rx_clk_i = rx_clk_oe ? rx_clk_o : 1'h0;
  initial mdc_pin = 1'h0;
  // Clock runs only within a burst, at 5 MHz
  task automatic mdc_burst(input int n);
    repeat (n) begin
      #100 mdc_pin = 1'h1;
      #100 mdc_pin = 1'h0;
    end
  endtask
endmodule

// *** bench/phy_rx_pins_properties.sv ***
// Concurrent checks on the receive-side pin block
`timescale 1ns/1ns
module phy_rx_pins_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic por_n,
  input wire logic link_clk,
  input wire logic rmii_mode,
  input wire logic rmii_master,
  input wire logic speed_100,
  input wire logic mdc_pin,
  input wire logic mdc_rise,
  input wire logic core_rx_dv,
  input wire logic core_crs,
  input wire logic core_rx_err,
  input wire logic rx_dv_o,
  input wire logic rx_er_o,
  input wire logic [3:0] rxd_oe,
  input wire logic rx_clk_oe,
  input wire logic tx_clk_oe,
  input wire logic int_mode,
  input wire logic int_req,
  input wire logic int_i,
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic power_down
);
  wire rst_any = !(arst_n && por_n);
  property p_mdc;
    @(posedge sys_clk) disable iff (rst_any) $rose(mdc_pin) |-> ##[1:4] mdc_rise;
  endproperty
  a_mdc: assert property (p_mdc) else $error("mdc edge lost");
  property p_pd;
    @(posedge sys_clk) disable iff (rst_any)
      (!int_mode && !int_i)[*5] |-> power_down;
  endproperty
  a_pd: assert property (p_pd) else $error("no power-down");
  property p_od;
    @(posedge sys_clk) disable iff (rst_any)
      int_oe == (int_mode && int_req) && !int_o;
  endproperty
  a_od: assert property (p_od) else $error("bad open drain");
  property p_boot;
    @(posedge sys_clk) disable iff (rst_any) $rose(arst_n && por_n) |->
      (!rx_clk_oe && !tx_clk_oe && rxd_oe == 4'h0)[*8];
  endproperty
  a_boot: assert property (p_boot) else $error("early drive");
  property p_slave;
    @(posedge link_clk) disable iff (rst_any)
      (rmii_mode && !rmii_master)[*6] |-> !rx_clk_oe;
  endproperty
  a_slave: assert property (p_slave) else $error("clock driven");
  property p_rmii_pins;
    @(posedge link_clk) disable iff (rst_any)
      rmii_mode[*6] |-> !tx_clk_oe && rxd_oe[3:2] == 2'h0;
  endproperty
  a_rmii_pins: assert property (p_rmii_pins) else $error("pin used");
  property p_crs_dv;
    @(posedge link_clk) disable iff (rst_any)
      rmii_mode[*6] |-> rx_dv_o == $past(core_crs || core_rx_dv);
  endproperty
  a_crs_dv: assert property (p_crs_dv) else $error("bad valid");
  property p_err;
    @(posedge link_clk) disable iff (rst_any)
      (rmii_mode || speed_100)[*6] |-> rx_er_o == $past(core_rx_err);
  endproperty
  a_err: assert property (p_err) else $error("bad error out");
  c_pd: cover property (@(posedge sys_clk) $rose(power_down));
  c_int: cover property (@(posedge sys_clk) int_oe);
  c_err: cover property (@(posedge link_clk) rx_er_o && !rx_dv_o);
endmodule
bind phy_rx_pins phy_rx_pins_checker phy_rx_pins_checker_inst (.sys_clk,
  .arst_n, .por_n, .link_clk, .rmii_mode, .rmii_master, .speed_100,
  .mdc_pin, .mdc_rise, .core_rx_dv, .core_crs, .core_rx_err, .rx_dv_o,
  .rx_er_o, .rxd_oe, .rx_clk_oe, .tx_clk_oe, .int_mode, .int_req, .int_i,
  .int_o, .int_oe, .power_down);

// *** bench/tb.sv ***
// Self-checking bench for the receive-side pin block
`timescale 1ns/1ns
module tb;
  logic sys_clk = 1'h0, link_clk = 1'h0, arst_n = 1'h0, por_n = 1'h0;
  logic rmii_mode = 1'h0, rmii_master = 1'h0, speed_100 = 1'h1;
  logic [3:0] core_rxd = 4'h0, rxd_o, rxd_oe;
  logic core_rx_dv = 1'h0, core_crs = 1'h0, core_rx_err = 1'h0;
  logic [5:0] strap = 6'h3a, strap_q;
  logic rx_dv_o, rx_dv_oe, rx_er_o, rx_er_oe, rx_clk_o, rx_clk_oe;
  logic tx_clk_o, tx_clk_oe, int_o, int_oe, int_mode = 1'h0;
  logic int_req = 1'h0, pd_drive_n = 1'h1;
  logic mdc_pin, mdc_rise, power_down, rx_clk_seen;
  wire [3:0] rxd_i;
  wire rx_dv_i, rx_er_i, rx_clk_i, int_i;
  int failures = 0, check_count = 0;
  // Strap levels show wherever the device does not drive
  assign rxd_i = (rxd_o & rxd_oe) | (strap[3:0] & ~rxd_oe);
  assign rx_dv_i = rx_dv_oe ? rx_dv_o : strap[4];
  assign rx_er_i = rx_er_oe ? rx_er_o : strap[5];
  initial forever #25 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever begin
      #62 link_clk = 1'h1;
      #63 link_clk = 1'h0;
    end
  end
  phy_rx_pins #(.DIV(2)) phy_rx_pins_inst (.sys_clk, .arst_n, .por_n,
    .link_clk, .rmii_mode, .rmii_master, .speed_100, .mdc_pin, .mdc_rise,
    .core_rxd, .core_rx_dv, .core_crs, .core_rx_err, .rxd_i, .rxd_o,
    .rxd_oe, .rx_dv_i, .rx_dv_o, .rx_dv_oe, .rx_er_i, .rx_er_o, .rx_er_oe,
    .rx_clk_i, .rx_clk_o, .rx_clk_oe, .tx_clk_o, .tx_clk_oe, .int_i, .int_o,
    .int_oe, .int_mode, .int_req, .power_down, .strap_q, .rx_clk_seen);
  mac_station_model mac_station_model_inst (.mdc_pin, .pd_drive_n, .int_o,
    .int_oe, .int_i, .rx_clk_o, .rx_clk_oe, .rx_clk_i);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic sys(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic lnk(input int n);
    repeat (n) @(negedge link_clk);
  endtask
  task automatic t_strap;
    chk(strap_q, 6'h3a);
    strap = 6'h05;
    arst_n = 1'h0;
    sys(1);
    chk({rxd_oe, rx_clk_oe, tx_clk_oe, rx_dv_oe, rx_er_oe}, 8'h00);
    sys(5);
    arst_n = 1'h1;
    sys(30);
    chk(strap_q, 6'h25);
    strap = 6'h3a;
  endtask
  task automatic t_mii100;
    lnk(1);
    core_rxd = 4'h5;
    core_rx_dv = 1'h1;
    lnk(1);
    chk({rxd_o, rx_dv_o, rx_er_o}, 6'h16);
    core_rx_dv = 1'h0;
    core_rx_err = 1'h1;
    lnk(1);
    chk({rxd_o, rx_dv_o, rx_er_o}, 6'h15);
    chk({rxd_oe, rx_clk_oe, tx_clk_oe, rx_dv_oe, rx_er_oe}, 8'hff);
    core_rx_err = 1'h0;
  endtask
  task automatic t_10m;
    logic tp, rp;
    int nt, nr;
    nt = 0;
    nr = 0;
    speed_100 = 1'h0;
    lnk(8);
    tp = tx_clk_o;
    rp = rx_clk_o;
    repeat (40) begin
      @(negedge link_clk);
      if (tx_clk_o && !tp) nt++;
      if (rx_clk_o && !rp) nr++;
      tp = tx_clk_o;
      rp = rx_clk_o;
    end
    chk(nt[7:0], 8'h14);
    chk(nr[7:0], 8'h14);
    sys(1);
    speed_100 = 1'h1;
  endtask
  task automatic t_rmii;
    rmii_mode = 1'h1;
    rmii_master = 1'h1;
    lnk(8);
    core_crs = 1'h1;
    core_rxd = 4'hf;
    lnk(2);
    chk({rxd_o, rx_dv_o}, 5'h07);
    chk({rxd_oe, rx_clk_oe, tx_clk_oe}, 6'h0e);
    #70 chk({rx_clk_o, link_clk}, 2'h3);
    sys(1);
    rmii_master = 1'h0;
    lnk(8);
    chk({rx_clk_oe, rx_clk_seen}, 2'h0);
    sys(1);
    rmii_mode = 1'h0;
    core_crs = 1'h0;
  endtask
  task automatic t_int;
    pd_drive_n = 1'h0;
    sys(6);
    chk(power_down, 1'h1);
    pd_drive_n = 1'h1;
    sys(4);
    chk(power_down, 1'h0);
    int_mode = 1'h1;
    int_req = 1'h1;
    sys(1);
    chk({int_oe, int_o, int_i, power_down}, 4'h8);
    int_req = 1'h0;
    sys(1);
    chk({int_oe, int_i}, 2'h1);
    int_mode = 1'h0;
  endtask
  task automatic t_mdc;
    int n;
    n = 0;
    fork
      mac_station_model_inst.mdc_burst(3);
      repeat (30) begin
        @(negedge sys_clk);
        if (mdc_rise === 1'h1) n++;
      end
    join
    chk(n[7:0], 8'h03);
  endtask
  initial begin
    sys(6);
    arst_n = 1'h1;
    por_n = 1'h1;
    sys(30);
    t_strap;
    t_mii100;
    t_10m;
    t_rmii;
    t_int;
    t_mdc;
    stop_test;
  end
  initial begin
    #200000;
    failures++;
    stop_test;
  end
endmodule
